// ===== gpb_pins.v
// gpb_pins.v: 24 two-way pins in three banks, 8 input-only pins
// assumes: control bits arrive as ports from software-facing logic on clk;
// pad levels are asynchronous and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "gpb_map.vh"

module gpb_pins (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // pads of two-way pins
  input  wire [23:0] pad_in,
  output reg  [23:0] pad_out,
  output reg  [23:0] pad_oe,
  // pads of input-only pins
  input  wire [7:0]  input_only_pin,
  // bank domain: 1 = secure bank
  input  wire [2:0]  bank_secure,
  // requester of the current access: 1 = secure
  input  wire        access_secure,
  // register writes, per-pin strobes; wr_dest_en is one strobe for the destination
  input  wire [23:0] wr_out_en,
  input  wire [23:0] wr_out_data,
  input  wire [23:0] wr_oe_en,
  input  wire [23:0] wr_oe_data,
  input  wire [23:0] wr_irq_en_en,
  input  wire [23:0] wr_irq_en_data,
  input  wire [23:0] wr_pol_en,
  input  wire [23:0] wr_pol_data,
  input  wire        wr_dest_en,
  input  wire [2:0]  wr_dest_data,
  // slot reset code, written as a positive number
  input  wire        wr_slot_en,
  input  wire [5:0]  wr_slot_code,
  // readback
  output reg  [23:0] pin_level,
  output reg  [7:0]  input_only_level,
  output reg  [23:0] out_value,
  output reg  [23:0] out_enable,
  output reg  [23:0] irq_enable,
  output reg  [23:0] irq_polarity,
  // interrupt consumers
  output reg  [2:0]  irq_dest,
  // debug chain control
  output reg         debug_chain_split,
  output reg         chain_split_select
);

  wire [23:0] pin_sync;
  wire [7:0]  in_sync;
  wire [23:0] bank_ok;
  reg  [2:0]  dest_en;
  wire [23:0] plain_out;
  wire [23:0] plain_oe;
  wire [23:0] next_out;
  wire [23:0] next_oe;
  wire [23:0] next_ie;
  wire [23:0] next_pol;
  wire [23:0] pin_cause;
  wire        slot_take;
  wire        any_irq;

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  gpb_sync #(.WIDTH(`GPB_NUM_PINS)) u_sync_pins (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (pad_in),
    .sync_out (pin_sync)
  );

  gpb_sync #(.WIDTH(`GPB_NUM_INPUTS)) u_sync_inputs (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (input_only_pin),
    .sync_out (in_sync)
  );

  // ****************************************************************
  // bank access gating
  // ****************************************************************
  // a non-secure requester may not touch a secure bank
  genvar b;
  generate
    for (b = 0; b < `GPB_NUM_BANKS; b = b + 1) begin : g_bank
      assign bank_ok[b*`GPB_BANK_WIDTH +: `GPB_BANK_WIDTH] =
        {`GPB_BANK_WIDTH{access_secure | ~bank_secure[b]}};
    end
  endgenerate

  // slot code is gated by the domain of the bank that holds it
  assign slot_take = wr_slot_en & bank_ok[`GPB_SLOT_LSB];

  // ****************************************************************
  // per-pin next state
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < `GPB_NUM_PINS; i = i + 1) begin : g_pin
      wire take_out;
      wire take_oe;
      wire take_ie;
      wire take_pol;

      assign take_out = wr_out_en[i] & bank_ok[i];
      assign take_oe  = wr_oe_en[i] & bank_ok[i];
      assign take_ie  = wr_irq_en_en[i] & bank_ok[i];
      assign take_pol = wr_pol_en[i] & bank_ok[i];

      assign plain_out[i] = take_out ? wr_out_data[i] : out_value[i];
      assign plain_oe[i]  = take_oe ? wr_oe_data[i] : out_enable[i];
      assign next_ie[i]   = take_ie ? wr_irq_en_data[i] : irq_enable[i];
      assign next_pol[i]  = take_pol ? wr_pol_data[i] : irq_polarity[i];

      // polarity 1 = active high; a pin that drives its pad never interrupts
      assign pin_cause[i] = irq_enable[i] & ~out_enable[i] &
                            ~(pin_sync[i] ^ irq_polarity[i]);

      // slot write beats a plain write on the same pin; code is active low
      if ((i >= `GPB_SLOT_LSB) && (i <= `GPB_SLOT_MSB)) begin : g_slot
        assign next_out[i] = slot_take ? ~wr_slot_code[i-`GPB_SLOT_LSB]
                                       : plain_out[i];
        assign next_oe[i]  = slot_take | plain_oe[i];
      end else begin : g_plain
        assign next_out[i] = plain_out[i];
        assign next_oe[i]  = plain_oe[i];
      end
    end
  endgenerate

  assign any_irq = |pin_cause;

  // ****************************************************************
  // control state
  // ****************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_value    <= `GPB_RST_PINS;
      out_enable   <= `GPB_RST_PINS;
      irq_enable   <= `GPB_RST_PINS;
      irq_polarity <= `GPB_RST_PINS;
      dest_en      <= `GPB_RST_DEST;
    end else begin
      out_value    <= next_out;
      out_enable   <= next_oe;
      irq_enable   <= next_ie;
      irq_polarity <= next_pol;
      if (wr_dest_en) begin
        dest_en <= wr_dest_data;
      end
    end
  end

  // ****************************************************************
  // pad drive
  // ****************************************************************
  // own copy of the drive, so the pads leave straight from a flop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out <= `GPB_RST_PINS;
      pad_oe  <= `GPB_RST_PINS;
    end else begin
      // push-pull: pad_out and pad_oe both follow the next state as written
      pad_out <= next_out;
      pad_oe  <= next_oe;
    end
  end

  // ****************************************************************
  // readback
  // ****************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_level        <= `GPB_RST_PINS;
      input_only_level <= `GPB_RST_INPUTS;
    end else begin
      pin_level        <= pin_sync;
      // input-only pins: read-only, no drive, no interrupt path
      input_only_level <= in_sync;
    end
  end

  // ****************************************************************
  // interrupt consumers
  // ****************************************************************
  // level, not sticky: drops one cycle after its cause goes away
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_dest <= `GPB_RST_DEST;
    end else begin
      irq_dest <= {`GPB_NUM_DEST{any_irq}} & dest_en;
    end
  end

  // ****************************************************************
  // debug chain control
  // ****************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_chain_split  <= 1'h0;
      chain_split_select <= 1'h0;
    end else begin
      // low level chains all three debug ports
      debug_chain_split  <= in_sync[`GPB_CHAIN_BIT];
      chain_split_select <= in_sync[`GPB_CHAIN_BIT];
    end
  end

endmodule

`default_nettype wire

// ===== gpb_map.vh
// gpb_map.vh: constants of the general purpose pin block
// assumes: included by gpb design files only
`ifndef GPB_MAP_VH
`define GPB_MAP_VH

// ****************************************************************
// sizes
// ****************************************************************
`define GPB_NUM_PINS     24
`define GPB_NUM_BANKS    3
`define GPB_BANK_WIDTH   8
`define GPB_NUM_INPUTS   8
`define GPB_NUM_DEST     3

// ****************************************************************
// field positions
// ****************************************************************
`define GPB_CHAIN_BIT    3
`define GPB_SLOT_LSB     16
`define GPB_SLOT_MSB     21

// ****************************************************************
// reset values
// ****************************************************************
`define GPB_RST_PINS     24'h000000
`define GPB_RST_BANKS    3'h0
`define GPB_RST_INPUTS   8'h00
`define GPB_RST_DEST     3'h0

`endif

// ===== gpb_sync.v
// gpb_sync.v: two-stage synchroniser for a vector of pin levels
// assumes: inputs are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none

module gpb_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // meta is read only by sync_out
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// ===== gpb_checker.sv
// gpb_checker.sv: port assertions for gpb_pins
// assumes: bound into gpb_pins, one clock
`timescale 1ns/1ps
`default_nettype none
module gpb_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // pads
  input wire logic [23:0] pad_in,
  input wire logic [23:0] pad_out,
  input wire logic [23:0] pad_oe,
  input wire logic [7:0]  input_only_pin,
  // writes
  input wire logic [2:0]  bank_secure,
  input wire logic        access_secure,
  input wire logic [23:0] wr_oe_en,
  input wire logic [23:0] wr_oe_data,
  input wire logic        wr_slot_en,
  input wire logic [5:0]  wr_slot_code,
  // readback and consumers
  input wire logic [23:0] pin_level,
  input wire logic [7:0]  input_only_level,
  input wire logic [23:0] out_enable,
  input wire logic [23:0] irq_enable,
  input wire logic [2:0]  irq_dest,
  input wire logic        debug_chain_split,
  input wire logic        chain_split_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_oe_write: assert property (wr_oe_en[0] && !bank_secure[0] |=>
    out_enable[0] == $past(wr_oe_data[0])) else $error("oe write");
  chk_oe_pad: assert property (pad_oe[15:0] == out_enable[15:0]) else $error("pad oe");
  chk_bank_refuse: assert property (wr_oe_en[8] && bank_secure[1] && !access_secure
    |=> $stable(out_enable[8])) else $error("bank gate");
  chk_pin_sync: assert property ($stable(pad_in) [*4] |-> pin_level == pad_in)
    else $error("pin level");
  chk_chain_sel: assert property ($stable(input_only_pin) [*4] |->
    input_only_level == input_only_pin && debug_chain_split == input_only_pin[3]
    && chain_split_select == input_only_pin[3]) else $error("input only");
  chk_slot_code: assert property (wr_slot_en && !bank_secure[2] |=>
    pad_out[21:16] == ~$past(wr_slot_code) && &pad_oe[21:16]) else $error("slot");
  chk_irq_quiet: assert property ((irq_enable == 24'h0) [*4] |-> irq_dest == 3'h0)
    else $error("irq");
  chk_reset_idle: assert property ($rose(rst_n) |-> pad_oe == 24'h0 && irq_dest == 3'h0)
    else $error("reset");
endmodule
bind gpb_pins gpb_checker u_chk (.*);
`default_nettype wire

// ===== gpb_board.sv
// gpb_board.sv: board around the two-way pads
// assumes: bench picks the pins driven from outside
`timescale 1ns/1ps
`default_nettype none
module gpb_board (
  input  wire logic [23:0] pad_out,
  input  wire logic [23:0] pad_oe,
  input  wire logic [23:0] ext_en,
  input  wire logic [23:0] ext_val,
  output wire logic [23:0] pad_in
);
  // released pads float high on the pull-up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & (ext_en & ext_val | ~ext_en));
endmodule
`default_nettype wire

// ===== gpb_pins_tb.sv
// gpb_pins_tb.sv: self-checking bench for gpb_pins
// assumes: board model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module gpb_pins_tb;
  logic        clk = 0, rst_n = 0, access_secure = 0, wr_dest_en = 0, wr_slot_en = 0;
  logic [23:0] wr_out_en = 0, wr_out_data = 0, wr_oe_en = 0, wr_oe_data = 0, ext_en = 0;
  logic [23:0] wr_irq_en_en = 0, wr_irq_en_data = 0, wr_pol_en = 0, wr_pol_data = 0;
  logic [23:0] ext_val = 0, pad_in, pad_out, pad_oe, pin_level, out_value, out_enable;
  logic [23:0] irq_enable, irq_polarity;
  logic [7:0]  input_only_pin = 0, input_only_level;
  logic [5:0]  wr_slot_code = 0;
  logic [2:0]  bank_secure = 0, wr_dest_data = 0, irq_dest;
  logic        debug_chain_split, chain_split_select;
  int          fail_count = 0, check_count = 0;
  gpb_pins u_dut (.*);
  gpb_board u_board (.*);
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [23:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // extra idle edge so back-to-back calls never re-raise in one step
  task automatic wr_pin(input logic [23:0] m, o, e);
    wr_out_en = m;
    wr_out_data = o;
    wr_oe_en = m;
    wr_oe_data = e;
    tick(1);
    wr_out_en = 0;
    wr_oe_en = 0;
    tick(1);
  endtask
  task automatic t_drive;
    wr_pin(24'h81, 24'h80, 24'h81);
    chk(pad_out | pad_oe, 24'h81, "pads");
    chk(out_value, 24'h80, "out_value");
    chk(pad_oe, 24'h81, "pad_oe");
    tick(4);
    chk(pin_level, 24'hfffffe, "level");
    wr_pin(24'h1, 24'h0, 24'h0);
    tick(4);
    chk(pin_level, 24'hffffff, "level");
  endtask
  task automatic t_irq;
    wr_pol_en = 24'h2;
    wr_pol_data = 24'h2;
    wr_irq_en_en = 24'h2;
    wr_irq_en_data = 24'h2;
    wr_dest_en = 1;
    for (int d = 0; d < 3; d++) begin
      wr_dest_data = 3'h1 << d;
      tick(4);
      chk(irq_dest, 24'h1 << d, "irq");
    end
    chk(irq_enable, 24'h2, "irq_enable");
    chk(irq_polarity, 24'h2, "irq_polarity");
    wr_pol_data = 0;
    tick(4);
    chk(irq_dest, 24'h0, "irq");
    chk(irq_polarity, 24'h0, "irq_polarity");
    ext_en = 24'h2;
    tick(4);
    chk(irq_dest, 24'h4, "irq");
    wr_pol_en = 0;
    wr_dest_en = 0;
    wr_pin(24'h2, 24'h0, 24'h2);
    chk(irq_dest, 24'h0, "irq");
    wr_pin(24'h2, 24'h0, 24'h0);
    chk(irq_dest, 24'h4, "irq");
    wr_irq_en_data = 0;
    tick(4);
    chk(irq_dest, 24'h0, "irq");
    wr_irq_en_en = 0;
  endtask
  task automatic t_gpi;
    for (int v = 0; v < 2; v++) begin
      input_only_pin = v ? 8'h08 : 8'ha5;
      tick(4);
      chk(input_only_level, input_only_pin, "gpi");
      chk(debug_chain_split, input_only_pin[3], "split");
      chk(chain_split_select, input_only_pin[3], "select");
    end
  endtask
  task automatic t_secure;
    bank_secure = 3'h2;
    wr_pin(24'h100, 24'h0, 24'h100);
    chk(out_enable, 24'h80, "oe");
    access_secure = 1;
    wr_pin(24'h100, 24'h0, 24'h100);
    chk(out_enable, 24'h180, "oe");
  endtask
  task automatic t_slot;
    wr_slot_code = 6'h2a;
    wr_slot_en = 1;
    tick(1);
    chk({pad_oe[21:16], pad_out[21:16]}, 24'hfd5, "slot");
    bank_secure = 3'h4;
    access_secure = 0;
    wr_slot_code = 6'h0;
    tick(1);
    wr_slot_en = 0;
    chk(pad_out[21:16], 24'h15, "slot");
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    tick(16);
    rst_n = 1;
    tick(1);
    chk(pad_oe | irq_enable | irq_dest, 24'h0, "reset");
    t_drive;
    t_irq;
    t_gpi;
    t_secure;
    t_slot;
    tally_and_finish;
  end
  initial begin
    #100us;
    fail_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
